/* File: design/key_port_pkg.sv */
package key_port_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_KEY_SCAN_PORT  = 8'h00;
    localparam logic [7:0] OFS_KEY_SENSE_IN   = 8'h04;
    localparam logic [7:0] OFS_FIRST_CTRL     = 8'h08;
    localparam logic [7:0] OFS_SECOND_CTRL    = 8'h0C;
    localparam logic [7:0] OFS_CPU_COMMAND    = 8'h10;
    localparam logic [7:0] OFS_CPU_STATUS     = 8'h14;

    // reset values
    localparam logic [7:0] RST_KEY_SCAN_PORT  = 8'hFF;
    localparam logic [7:0] RST_SECOND_CTRL    = 8'h26;
    localparam logic [3:0] RST_POINTER_HIGH   = 4'h0;

    // second control register fields
    localparam int SC_SENSE_A_INPUT   = 0;    // 1: sense pin a in input mode
    localparam int SC_KEY_SCAN_OUTPUT = 1;    // 1: key-scan lines drive
    localparam int SC_LED_OUTPUT      = 2;    // 1: led sense pin drives
    localparam int SC_STOP_WAKE_EN    = 3;    // 1: stop-wake pin may release standby
    localparam int SC_SENSE_PULLDOWN  = 4;    // 1: pull-downs on sense a and led pin while the led pin is an input
    localparam int SC_KEY_PULLDOWN    = 5;    // 1: pull-downs on key inputs

    // first control register fields
    localparam int FC_RETAIN_BIT      = 3;
    localparam int FC_POINTER_LSB     = 4;
    localparam int FC_POINTER_MSB     = 7;

    // input register fields
    localparam int IN_FIXED_ONE       = 0;
    localparam int IN_STOP_WAKE       = 1;
    localparam int IN_SENSE_A         = 2;
    localparam int IN_LED_SENSE       = 3;
    localparam int IN_KEY_LSB         = 4;

    // command register fields
    localparam int CMD_OPERAND_MSB    = 3;
    localparam int CMD_TEST_BIT       = 4;
    localparam int CMD_HALT_BIT       = 8;

    // status register fields
    localparam int ST_FLAG_BIT        = 0;
    localparam int ST_STANDBY_BIT     = 1;

    // low three operand bits of the status test
    localparam logic [2:0] OPND_KEY_A     = 3'b000;
    localparam logic [2:0] OPND_KEY_B     = 3'b011;
    localparam logic [2:0] OPND_KEY_C     = 3'b110;
    localparam logic [2:0] OPND_TIMER     = 3'b101;

    // bus codes
    localparam logic [1:0] HTRANS_NONSEQ  = 2'b10;
    localparam logic       HRESP_OKAY     = 1'b0;

    // standby sequencer
    typedef enum logic [0:0] {
        ST_RUN     = 1'b0,
        ST_STANDBY = 1'b1
    } run_state_e;

endpackage

/* File: design/key_port_status_flag.sv */
// Notes on behaviour
// - status test sets flag if selected condition holds, else clears it.
// - leaving standby through a release event sets the flag.
// - halt with release condition true sets flag and keeps running.
// - halt with flag one and no release clears flag, keeps running.
// - operand low bits 000/011/110 test key inputs; 101 tests timer zero.
// - operand top bit one also ORs in any high sense pin.
// - sense a and led count only as inputs; stop-wake only when enabled.
// - key-scan read gives pins in input mode, latch in output mode.
// - key-scan write always updates the output latch.
// - one control bit, bit 1, sets direction of all key-scan lines.
// - reset puts key-scan port in output mode with latch all ones.
// - key-scan pull-down connected only in input mode.
// - key input pull-downs switched by control bit 5, connected after reset.
// - input register: keys in bits 4-7, stop-wake bit 1, bit 0 one.
// - input bit 2 gives sense a level as input, one in off mode.
// - input bit 3 gives the led pin level in either mode.
// - reset sets key-scan port to FF and second control register to 26.
// - after reset input register shows bits 3, 2, 0 at one.
// - first control register resets to zero except retention flag.
// - sense a floats in off mode after reset; bit 0 enables input.
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps

module key_port_status_flag
    import key_port_pkg::*;
#(
    parameter int KEY_SCAN_W = 8,
    parameter int KEY_IN_W   = 4
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // key-scan lines
    input  wire logic [KEY_SCAN_W-1:0] key_scan_lines_in,
    output logic [KEY_SCAN_W-1:0]      key_scan_lines_out,
    output logic [KEY_SCAN_W-1:0]      key_scan_lines_oe,
    output logic                       key_scan_pulldown_en,
    // key inputs
    input  wire logic [KEY_IN_W-1:0]   key_input_lines,
    output logic                       key_input_pulldown_en,
    // sense pins
    input  wire logic                  sense_pin_a,
    output logic                       sense_pin_a_enable,
    output logic                       sense_pulldown_en,
    input  wire logic                  led_sense_pin_in,
    output logic                       led_sense_pin_out,
    output logic                       led_sense_pin_oe,
    input  wire logic                  stop_wake_sense_pin,
    output logic                       stop_wake_pulldown_en,
    // timer and supply monitor
    input  wire logic                  timer_count_zero,
    input  wire logic                  led_indicator,
    input  wire logic                  retention_detect_level,
    // cpu side
    output logic                       cpu_standby,
    output logic                       status_test_flag
);

    // the logic is written for the documented port widths only
    if (KEY_SCAN_W != 8 || KEY_IN_W != 4) begin : g_bad_width
        $error("key_port_status_flag: only 8 scan lines and 4 key inputs supported");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [KEY_SCAN_W-1:0] scan_meta;
    logic [KEY_SCAN_W-1:0] scan_sync;
    logic [KEY_IN_W-1:0]   key_meta;
    logic [KEY_IN_W-1:0]   key_sync;
    logic                  sense_a_meta;
    logic                  sense_a_sync;
    logic                  led_meta;
    logic                  led_sync;
    logic                  wake_meta;
    logic                  wake_sync;
    logic                  supply_meta;
    logic                  supply_sync;

    // two flops on every pin; only the second stage is read by logic
    always_ff @(posedge clk) begin
        scan_meta    <= key_scan_lines_in;
        scan_sync    <= scan_meta;
        key_meta     <= key_input_lines;
        key_sync     <= key_meta;
        sense_a_meta <= sense_pin_a;
        sense_a_sync <= sense_a_meta;
        led_meta     <= led_sense_pin_in;
        led_sync     <= led_meta;
        wake_meta    <= stop_wake_sense_pin;
        wake_sync    <= wake_meta;
        supply_meta  <= retention_detect_level;
        supply_sync  <= supply_meta;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave front end

    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] dp_addr;

    wire        bus_req   = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire        take_rd   = bus_req && !hwrite;
    wire        take_wr   = bus_req && hwrite;

    // data-phase write strobes, one per decoded offset
    wire        wr_scan   = wr_pend && (dp_addr == OFS_KEY_SCAN_PORT);
    wire        wr_first  = wr_pend && (dp_addr == OFS_FIRST_CTRL);
    wire        wr_second = wr_pend && (dp_addr == OFS_SECOND_CTRL);
    wire        wr_cmd    = wr_pend && (dp_addr == OFS_CPU_COMMAND);

    // address phase is captured; reads get one wait state so that hrdata
    // leaves a flop and still sees any write that landed just before
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            dp_addr   <= 8'h00;
            hreadyout <= 1'b1;
        end else begin
            wr_pend   <= take_wr;
            rd_pend   <= take_rd;
            hreadyout <= !take_rd;
            if (bus_req) begin
                dp_addr <= haddr[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // key-scan latch and control registers

    logic [KEY_SCAN_W-1:0] scan_latch;
    logic [7:0]            second_ctrl;
    logic [3:0]            pointer_high;
    logic                  retain_flag;

    wire scan_is_output = second_ctrl[SC_KEY_SCAN_OUTPUT];
    wire sense_a_input  = second_ctrl[SC_SENSE_A_INPUT];
    wire led_is_output  = second_ctrl[SC_LED_OUTPUT];
    wire wake_enabled   = second_ctrl[SC_STOP_WAKE_EN];

    // latch takes writes in either direction mode
    always_ff @(posedge clk) begin
        if (rst) begin
            scan_latch   <= RST_KEY_SCAN_PORT;
            second_ctrl  <= RST_SECOND_CTRL;
            pointer_high <= RST_POINTER_HIGH;
        end else begin
            if (wr_scan) begin
                scan_latch <= hwdata[KEY_SCAN_W-1:0];
            end
            if (wr_second) begin
                second_ctrl <= hwdata[7:0];
            end
            if (wr_first) begin
                pointer_high <= hwdata[FC_POINTER_MSB:FC_POINTER_LSB];
            end
        end
    end

    // retention flag survives reset and is only lost when the supply fell
    // below the retention level; a low supply beats a software set
    always_ff @(posedge clk) begin
        if (supply_sync) begin
            retain_flag <= 1'b0;
        end else if (wr_first && !rst) begin
            retain_flag <= hwdata[FC_RETAIN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back values

    wire [KEY_SCAN_W-1:0] scan_read  = scan_is_output ? scan_latch : scan_sync;
    wire                  sense_a_rd = sense_a_input ? sense_a_sync : 1'b1;
    wire [7:0]            input_read = {key_sync,
                                        led_sync,
                                        sense_a_rd,
                                        wake_sync,
                                        1'b1};
    wire [7:0]            first_read = {pointer_high, retain_flag, 3'b000};

    logic       flag;
    run_state_e state;

    wire [31:0] status_read = {30'h0000_0000, state == ST_STANDBY, flag};

    // address decode for reads; unmapped offsets read zero with OKAY
    wire [31:0] read_mux =
        (dp_addr == OFS_KEY_SCAN_PORT) ? {24'h00_0000, scan_read}  :
        (dp_addr == OFS_KEY_SENSE_IN)  ? {24'h00_0000, input_read} :
        (dp_addr == OFS_FIRST_CTRL)    ? {24'h00_0000, first_read} :
        (dp_addr == OFS_SECOND_CTRL)   ? {24'h00_0000, second_ctrl} :
        (dp_addr == OFS_CPU_STATUS)    ? status_read : 32'h0000_0000;

    // writes to the input register and to the status word have no decode
    // strobe at all, so nothing they carry can reach a pin or latch
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
            hresp  <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
            if (rd_pend) begin
                hrdata <= read_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status test condition

    wire [3:0] operand   = hwdata[CMD_OPERAND_MSB:0];
    wire       do_test   = wr_cmd && hwdata[CMD_TEST_BIT];
    wire       do_halt   = wr_cmd && hwdata[CMD_HALT_BIT] && !hwdata[CMD_TEST_BIT];
    wire       any_key   = |key_sync;

    // the low operand bits pick keys or timer; other codes never match
    wire       low_cond  = ((operand[2:0] == OPND_KEY_A) ||
                            (operand[2:0] == OPND_KEY_B) ||
                            (operand[2:0] == OPND_KEY_C)) ? any_key :
                           (operand[2:0] == OPND_TIMER)   ? timer_count_zero
                                                          : 1'b0;

    // sense a and led pin count only when both sit in input mode
    wire       sense_pair_in = sense_a_input && !led_is_output;
    wire       sense_cond    = (sense_pair_in && (sense_a_sync || led_sync)) ||
                               (wake_enabled && wake_sync);
    wire       test_result   = low_cond || (operand[CMD_OPERAND_MSB] && sense_cond);

    // standby is left on a key press or an enabled stop-wake level
    wire       release_cond  = any_key || (wake_enabled && wake_sync);

    ////////////////////////////////////////////////////////////////////////////////
    // flag and standby sequencer

    logic       next_flag;
    run_state_e next_state;

    always_comb begin
        next_flag  = flag;
        next_state = state;
        case (state)
            ST_RUN: begin
                if (do_test) begin
                    next_flag = test_result;
                end else if (do_halt) begin
                    if (release_cond) begin
                        next_flag = 1'b1;
                    end else if (flag) begin
                        next_flag = 1'b0;
                    end else begin
                        next_state = ST_STANDBY;
                    end
                end
            end
            ST_STANDBY: begin
                if (release_cond) begin
                    next_flag  = 1'b1;
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // the cpu is stopped while in standby, so commands are not expected then
    always_ff @(posedge clk) begin
        if (rst) begin
            flag  <= 1'b0;
            state <= ST_RUN;
        end else begin
            flag  <= next_flag;
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drivers, all registered

    // one cycle behind the control bits; harmless for slow pad controls
    always_ff @(posedge clk) begin
        if (rst) begin
            key_scan_lines_out    <= RST_KEY_SCAN_PORT;
            key_scan_lines_oe     <= {KEY_SCAN_W{1'b1}};
            key_scan_pulldown_en  <= 1'b0;
            key_input_pulldown_en <= RST_SECOND_CTRL[SC_KEY_PULLDOWN];
            sense_pin_a_enable    <= 1'b0;
            sense_pulldown_en     <= 1'b0;
            led_sense_pin_out     <= 1'b1;
            led_sense_pin_oe      <= 1'b1;
            stop_wake_pulldown_en <= 1'b0;
            cpu_standby           <= 1'b0;
            status_test_flag      <= 1'b0;
        end else begin
            key_scan_lines_out    <= scan_latch;
            key_scan_lines_oe     <= {KEY_SCAN_W{scan_is_output}};
            key_scan_pulldown_en  <= !scan_is_output;
            key_input_pulldown_en <= second_ctrl[SC_KEY_PULLDOWN];
            sense_pin_a_enable    <= sense_a_input;
            sense_pulldown_en     <= second_ctrl[SC_SENSE_PULLDOWN] && !led_is_output;
            led_sense_pin_out     <= led_indicator;
            led_sense_pin_oe      <= led_is_output;
            stop_wake_pulldown_en <= wake_enabled;
            cpu_standby           <= (next_state == ST_STANDBY);
            status_test_flag      <= next_flag;
        end
    end

endmodule // key_port_status_flag

/* File: dv/key_matrix_model.sv */
`timescale 1ns/10ps
module key_matrix_model (
    // clock and levels the far side applies
    input wire logic       clk,
    input wire logic [7:0] scan_level,
    input wire logic [3:0] keys,
    input wire logic       sa,
    input wire logic       led_lv,
    input wire logic       sw,
    // device pads
    input wire logic [7:0] scan_out,
    input wire logic [7:0] scan_oe,
    input wire logic       scan_pd,
    input wire logic       key_pd,
    input wire logic       sa_en,
    input wire logic       led_out,
    input wire logic       led_oe,
    output logic [7:0]     scan_in,
    output logic [3:0]     key_pin,
    output logic           sa_pin,
    output logic           led_pin,
    output logic           sw_pin
);
    logic flip = 1'b0;

    // a floating line wanders every cycle so nothing may lean on its last value
    always @(posedge clk) flip <= ~flip;

    // device drive wins; released lines show the far side or wander without pull-down
    assign scan_in = scan_oe & scan_out | ~scan_oe & (scan_level | {8{~scan_pd & flip}});
    assign key_pin = keys | {4{~key_pd & flip}};
    assign sa_pin  = sa_en ? sa : flip;  // off mode pin is high impedance
    assign led_pin = led_oe ? led_out : led_lv;
    assign sw_pin  = sw;
endmodule // key_matrix_model

/* File: dv/key_port_status_flag_asserts.sv */
`timescale 1ns/10ps
module key_port_checker
    import key_port_pkg::*;
#(
    parameter int KEY_SCAN_W = 8,
    parameter int KEY_IN_W   = 4
) (
    // clock, reset and bus
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  hsel,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    // pads and cpu side
    input wire logic [KEY_SCAN_W-1:0] key_scan_lines_out,
    input wire logic [KEY_SCAN_W-1:0] key_scan_lines_oe,
    input wire logic                  key_scan_pulldown_en,
    input wire logic [KEY_IN_W-1:0]   key_input_lines,
    input wire logic                  key_input_pulldown_en,
    input wire logic                  sense_pin_a_enable,
    input wire logic                  cpu_standby,
    input wire logic                  status_test_flag
);
    // one clock domain, so clocking and reset are declared once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    okay_resp_a: assert property (hresp == HRESP_OKAY)
        else $error("bus response not okay");
    read_wait_a: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read data phase not two cycles");
    read_upper_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    scan_dir_a: assert property (key_scan_lines_oe == '0 || key_scan_lines_oe == '1)
        else $error("key-scan lines split in direction");
    scan_pull_a: assert property (key_scan_pulldown_en == !key_scan_lines_oe[0])
        else $error("key-scan pull-down in output mode");
    reset_pads_a: assert property ($fell(rst) |-> key_scan_lines_out == '1
        && key_scan_lines_oe == '1 && key_input_pulldown_en && !sense_pin_a_enable)
        else $error("pads wrong after reset");
    wake_flag_a: assert property ($fell(cpu_standby) |-> status_test_flag)
        else $error("standby left without flag set");
    halt_flag_a: assert property ($rose(cpu_standby) |-> !$past(status_test_flag))
        else $error("standby entered with flag set");
    // two synchroniser flops plus the release edge fit in four cycles
    wake_time_a: assert property (cpu_standby && key_input_lines != '0 |-> ##[1:4] !cpu_standby)
        else $error("key press did not end standby");
endmodule // key_port_checker

bind key_port_status_flag key_port_checker #(
    .KEY_SCAN_W(KEY_SCAN_W),
    .KEY_IN_W  (KEY_IN_W)
) u_checker (
    .clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .key_scan_lines_out, .key_scan_lines_oe, .key_scan_pulldown_en, .key_input_lines,
    .key_input_pulldown_en, .sense_pin_a_enable, .cpu_standby, .status_test_flag
);

/* File: dv/key_port_status_flag_bench.sv */
`timescale 1ns/10ps
module key_port_status_flag_bench
    import key_port_pkg::*;
;
    // bus side
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic        hreadyout, hresp;
    // far side, timer and supply
    logic [7:0]  scan_level = 8'h00;
    logic [3:0]  keys = 4'h0, key_pin;
    logic        sa = 1'b0, led_lv = 1'b0, sw = 1'b0, tz = 1'b0, led_ind = 1'b1, ret_low = 1'b1;
    // pads and checking
    logic [7:0]  scan_in, scan_out, scan_oe, ctrl, d;
    logic        scan_pd, key_pd, sa_en, sense_pd, led_out, led_oe, sa_pin, led_pin, sw_pin;
    logic        sw_pd, standby, flag, rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    logic [15:0] cfg [5];
    integer      failures = 0, total_checks = 0, cycles = 0, seed = 8, i, j;

    key_port_status_flag u_dut (
        .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .key_scan_lines_in(scan_in), .key_scan_lines_out(scan_out),
        .key_scan_lines_oe(scan_oe), .key_scan_pulldown_en(scan_pd), .key_input_lines(key_pin),
        .key_input_pulldown_en(key_pd), .sense_pin_a(sa_pin), .sense_pin_a_enable(sa_en),
        .sense_pulldown_en(sense_pd), .led_sense_pin_in(led_pin), .led_sense_pin_out(led_out),
        .led_sense_pin_oe(led_oe), .stop_wake_sense_pin(sw_pin), .stop_wake_pulldown_en(sw_pd),
        .timer_count_zero(tz), .led_indicator(led_ind), .retention_detect_level(ret_low),
        .cpu_standby(standby), .status_test_flag(flag)
    );
    key_matrix_model u_keys (
        .clk, .scan_level, .keys, .sa, .led_lv, .sw, .scan_out, .scan_oe, .scan_pd, .key_pd,
        .sa_en, .led_out, .led_oe, .scan_in, .key_pin, .sa_pin, .led_pin, .sw_pin
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;

    task automatic miss(input string m);
        failures = failures + 1;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic ok, input string m);
        total_checks = total_checks + 1;
        if (ok !== 1'b1) miss(m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= {24'h0, a}; hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= v;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0);
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // condition of a status test worked out from the levels the bench applies
    function automatic logic cond(input logic [3:0] op, input logic [7:0] c);
        logic r;
        r = (op[2:0] == OPND_KEY_A || op[2:0] == OPND_KEY_B || op[2:0] == OPND_KEY_C) ? |keys
            : (op[2:0] == OPND_TIMER) ? tz : 1'b0;
        if (op[3]) r = r | (c[0] & ~c[2] & (sa | led_lv)) | (c[3] & sw);
        return r;
    endfunction

    // read results are matched, oldest note first, when the data phase completes
    always @(posedge clk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            rd_pend <= 1'b0;
            total_checks = total_checks + 1;
            if (exp_q.size() == 0 || hrdata !== exp_q[0]) miss("read data differs");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (hsel && hreadyout && htrans == HTRANS_NONSEQ && !hwrite) rd_pend <= 1'b1;
    end
    // hang guard, far above the eight hundred or so cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miss("run did not finish");
            end_of_test;
        end
    end

    initial begin
        cfg = '{16'h4026, 16'h0F26, 16'h0431, 16'h0221, 16'h012E};
        idle(4);
        rst <= 1'b0;
        ret_low <= 1'b0;
        chk(scan_oe === 8'hFF && scan_pd === 1'b0, "scan pads after reset");
        chk(key_pd === 1'b1 && sa_en === 1'b0, "key pull-down or sense a after reset");
        rd(OFS_KEY_SCAN_PORT, RST_KEY_SCAN_PORT);
        rd(OFS_SECOND_CTRL, RST_SECOND_CTRL);
        rd(OFS_FIRST_CTRL, 8'h00);
        rd(OFS_KEY_SENSE_IN, 8'h0D);
        wr(OFS_FIRST_CTRL, 32'h7F);
        rd(OFS_FIRST_CTRL, 8'h78);
        wr(OFS_KEY_SENSE_IN, 32'h00);
        rd(OFS_KEY_SENSE_IN, 8'h0D);
        rd(OFS_KEY_SCAN_PORT, 8'hFF);
        rd(8'h40, 8'h00);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(OFS_KEY_SCAN_PORT, {24'h0, d});
            rd(OFS_KEY_SCAN_PORT, d);
        end
        chk(scan_out === d, "latch not on pads");
        scan_level <= 8'hA5;
        wr(OFS_SECOND_CTRL, 32'h04);
        idle(4);
        chk(scan_oe === 8'h00 && scan_pd === 1'b1 && key_pd === 1'b0, "input mode pads");
        rd(OFS_KEY_SCAN_PORT, 8'hA5);
        wr(OFS_KEY_SCAN_PORT, 32'h3C);
        rd(OFS_KEY_SCAN_PORT, 8'hA5);
        wr(OFS_SECOND_CTRL, 32'h26);
        rd(OFS_KEY_SCAN_PORT, 8'h3C);
        $display("test scan port done");
        for (j = 0; j < 5; j++) begin
            {keys, tz, sa, led_lv, sw} <= cfg[j][15:8];
            ctrl = cfg[j][7:0];
            wr(OFS_SECOND_CTRL, {24'h0, ctrl});
            idle(4);
            rd(OFS_KEY_SENSE_IN, {keys, ctrl[2] ? led_ind : led_lv, ctrl[0] ? sa : 1'b1, sw, 1'b1});
            chk(sa_en === ctrl[0] && led_oe === ctrl[2] && sw_pd === ctrl[3]
                && sense_pd === (ctrl[4] & ~ctrl[2]) && led_out === led_ind, "sense pads");
            for (i = 0; i < 16; i++) begin
                wr(OFS_CPU_COMMAND, {27'h0, 1'b1, i[3:0]});
                rd(OFS_CPU_STATUS, {7'h0, cond(i[3:0], ctrl)});
            end
        end
        $display("test status test done");
        {keys, tz, sw} <= 6'b0100_0_0;
        wr(OFS_SECOND_CTRL, 32'h26);
        idle(4);
        wr(OFS_CPU_COMMAND, 32'h10);
        keys <= 4'h0;
        idle(4);
        wr(OFS_CPU_COMMAND, 32'h100);
        rd(OFS_CPU_STATUS, 8'h00);
        wr(OFS_CPU_COMMAND, 32'h100);
        rd(OFS_CPU_STATUS, 8'h02);
        keys <= 4'h2;
        idle(6);
        chk(standby === 1'b0 && flag === 1'b1, "no wake on key");
        rd(OFS_CPU_STATUS, 8'h01);
        wr(OFS_CPU_COMMAND, 32'h15);
        rd(OFS_CPU_STATUS, 8'h00);
        wr(OFS_CPU_COMMAND, 32'h100);
        rd(OFS_CPU_STATUS, 8'h01);
        // standby left through an enabled stop-wake level, no key pressed
        keys <= 4'h0;
        wr(OFS_SECOND_CTRL, 32'h2E);
        idle(4);
        wr(OFS_CPU_COMMAND, 32'h100);
        wr(OFS_CPU_COMMAND, 32'h100);
        rd(OFS_CPU_STATUS, 8'h02);
        sw <= 1'b1;
        idle(6);
        rd(OFS_CPU_STATUS, 8'h01);
        $display("test halt done");
        // reset in mid-run keeps the retention flag; only a low supply clears it
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd(OFS_FIRST_CTRL, 8'h08);
        rd(OFS_KEY_SCAN_PORT, RST_KEY_SCAN_PORT);
        ret_low <= 1'b1;
        idle(4);
        ret_low <= 1'b0;
        rd(OFS_FIRST_CTRL, 8'h00);
        $display("test mid-run reset done");
        end_of_test;
    end
endmodule // key_port_status_flag_bench
